// [hw/polss_defines.vh]
`ifndef POLSS_DEFINES_VH
`define POLSS_DEFINES_VH

// fault response codes
`define POLSS_RSP_RETRY_INF 3'h0
`define POLSS_RSP_RETRY_N 3'h1
`define POLSS_RSP_DELAY_OFF 3'h2
`define POLSS_RSP_RIDE 3'h3
`define POLSS_RSP_SHUT_NOW 3'h4
`define POLSS_RSP_DEFAULT 3'h4

// clock and timing
`define POLSS_CLK_MHZ 125
`define POLSS_MIN_DLY_US 2000
`define POLSS_DEF_DLY_US 10000
`define POLSS_DEF_RAMP_US 10000
`define POLSS_BOOT_US 10

// tracking and margining
`define POLSS_TRK_MODE_OFF 2'h0
`define POLSS_TRK_MODE_COIN 2'h1
`define POLSS_TRK_MODE_RATIO 2'h2
`define POLSS_TRK_RATIO_DEF 8'h32
`define POLSS_TRK_RATIO_FULL 8'h64
`define POLSS_MRG_DEF_PCT 8'h05
`define POLSS_MRG_NONE 2'h0
`define POLSS_MRG_HIGH 2'h1
`define POLSS_MRG_LOW 2'h2

// state codes
`define POLSS_ST_STRAP 3'h0
`define POLSS_ST_FACT 3'h1
`define POLSS_ST_USER 3'h2
`define POLSS_ST_BOOT 3'h3
`define POLSS_ST_OFF 3'h4
`define POLSS_ST_DELAY 3'h5
`define POLSS_ST_RAMP 3'h6
`define POLSS_ST_ON 3'h7

`endif

// [hw/polss_sequencer.v]
`timescale 1ns/1ps
`include "polss_defines.vh"
module polss_sequencer #(
	parameter VW = 12,
	parameter TW = 24,
	parameter NW = 4,
	parameter MIN_DLY_CYC = `POLSS_MIN_DLY_US * `POLSS_CLK_MHZ,
	parameter DEF_DLY_CYC = `POLSS_DEF_DLY_US * `POLSS_CLK_MHZ,
	parameter DEF_RAMP_CYC = `POLSS_DEF_RAMP_US * `POLSS_CLK_MHZ,
	parameter BOOT_CYC = `POLSS_BOOT_US * `POLSS_CLK_MHZ,
	parameter DEF_RETRY_CYC = DEF_DLY_CYC,
	parameter DEF_OC_LIMIT = 12'h800,
	parameter DEF_VTARGET = 12'h400
) (
	input mclk,
	input sys_rst,
	input enable_pin,
	input [4:0] strap_addr,
	input [VW-1:0] strap_vout,
	input [VW-1:0] fact_vout,
	input [VW-1:0] fact_oc_limit,
	input user_valid,
	input [VW-1:0] user_vout,
	input [2:0] user_oc_resp,
	input cmd_wr,
	input [VW-1:0] cmd_vout,
	input [VW-1:0] cmd_oc_limit,
	input [2:0] cmd_oc_resp,
	input [NW-1:0] cmd_retry_max,
	input [TW-1:0] cmd_retry_dly,
	input [TW-1:0] cmd_dly,
	input [TW-1:0] cmd_ramp,
	input [1:0] cmd_trk_mode,
	input [7:0] cmd_trk_ratio,
	input [7:0] cmd_mrg_pct,
	input [4:0] cmd_group_id,
	input cmd_share,
	input cmd_spread,
	input [1:0] mrg_sel,
	input [VW-1:0] iout,
	input [VW-1:0] track_voltage_input,
	input group_comm_bus_fault_in,
	input [4:0] group_comm_bus_id_in,
	output reg [VW-1:0] vref_ff,
	output reg pwm_en_ff,
	output reg diode_emul_ff,
	output reg overcurrent_protection_ff,
	output reg group_comm_bus_fault_out_ff,
	output reg [4:0] group_comm_bus_id_ff,
	output reg ready_ff,
	output reg [2:0] state_ff
);
	// ****************************************
	// input synchronisers
	// ****************************************
	// nothing but the second stage is read by logic
	reg en_s1_ff;
	reg en_s2_ff;
	reg gf_s1_ff;
	reg gf_s2_ff;
	// id travels through the same two stages so it lines up with the fault
	reg [4:0] id_s1_ff;
	reg [4:0] id_s2_ff;
	reg [VW-1:0] trk_s1_ff;
	reg [VW-1:0] trk_s2_ff;
	reg [VW-1:0] i_s1_ff;
	reg [VW-1:0] i_s2_ff;
	always @(posedge mclk) begin
		en_s1_ff <= enable_pin;
		en_s2_ff <= en_s1_ff;
		gf_s1_ff <= group_comm_bus_fault_in;
		gf_s2_ff <= gf_s1_ff;
		id_s1_ff <= group_comm_bus_id_in;
		id_s2_ff <= id_s1_ff;
		trk_s1_ff <= track_voltage_input;
		trk_s2_ff <= trk_s1_ff;
		i_s1_ff <= iout;
		i_s2_ff <= i_s1_ff;
	end

	// ****************************************
	// configuration store
	// ****************************************
	reg [VW-1:0] vtgt_ff;
	reg [VW-1:0] oclim_ff;
	reg [2:0] ocrsp_ff;
	reg [NW-1:0] rmax_ff;
	reg [TW-1:0] rdly_ff;
	reg [TW-1:0] dly_ff;
	reg [TW-1:0] ramp_ff;
	reg [1:0] trk_ff;
	reg [7:0] ratio_ff;
	reg [7:0] mpct_ff;
	reg share_ff;
	reg spread_ff;
	reg [TW-1:0] tmr_ff;
	reg [TW-1:0] oc_tmr_ff;
	reg [NW-1:0] retry_ff;
	reg latched_ff;
	reg [VW+8:0] acc_ff;

	wire booted = (state_ff != `POLSS_ST_STRAP) && (state_ff != `POLSS_ST_FACT) &&
		(state_ff != `POLSS_ST_USER) && (state_ff != `POLSS_ST_BOOT);
	wire [TW-1:0] eff_dly = (dly_ff < MIN_DLY_CYC[TW-1:0]) ? MIN_DLY_CYC[TW-1:0] : dly_ff;
	wire oc_now = (i_s2_ff > oclim_ff);

	// ****************************************
	// reference shaping
	// ****************************************
	wire [VW+8:0] vtgt_x = {9'h000, vtgt_ff};
	wire [7:0] mstep = mpct_ff;
	// percentages are scaled against a sized hundred
	wire [VW+8:0] pct_full = {{(VW+1){1'b0}}, `POLSS_TRK_RATIO_FULL};
	wire [VW+8:0] mrg_delta = (vtgt_x * {{(VW+1){1'b0}}, mstep}) / pct_full;
	wire [VW+8:0] trk_x = {9'h000, trk_s2_ff};
	wire [VW+8:0] trk_ratio_v = (trk_x * {{(VW+1){1'b0}}, ratio_ff}) / pct_full;
	wire [VW+8:0] trk_v = (trk_ff == `POLSS_TRK_MODE_COIN) ? trk_x : trk_ratio_v;
	wire [VW-1:0] trk_lim = (trk_v > vtgt_x) ? vtgt_ff : trk_v[VW-1:0];
	wire [VW+8:0] vmrg = (mrg_sel == `POLSS_MRG_HIGH) ? vtgt_x + mrg_delta :
		(mrg_sel == `POLSS_MRG_LOW) ? vtgt_x - mrg_delta : vtgt_x;
	// high margin saturates instead of wrapping to a low voltage
	wire [VW-1:0] vmrg_sat = (vmrg > {9'h000, {VW{1'b1}}}) ? {VW{1'b1}} : vmrg[VW-1:0];
	// step in 1/256 lsb per cycle, at least one so the ramp always ends
	wire [VW+TW+7:0] rs_num = {{TW{1'b0}}, vtgt_ff, 8'h00};
	wire [VW+TW+7:0] rs_den = {{(VW+8){1'b0}}, ramp_ff};
	wire [VW+TW+7:0] rs_quo = rs_num / rs_den;
	wire [VW+8:0] ramp_step = (ramp_ff == {TW{1'b0}}) ? {1'b0, vtgt_ff, 8'h00} :
		(rs_quo[VW+8:0] | {{(VW+8){1'b0}}, 1'b1});

	always @(posedge mclk) begin
		if (sys_rst) begin
			vtgt_ff <= {VW{1'b0}};
			oclim_ff <= {VW{1'b1}};
			ocrsp_ff <= `POLSS_RSP_DEFAULT;
			rmax_ff <= {NW{1'b0}};
			rdly_ff <= DEF_RETRY_CYC[TW-1:0];
			dly_ff <= DEF_DLY_CYC[TW-1:0];
			ramp_ff <= DEF_RAMP_CYC[TW-1:0];
			trk_ff <= `POLSS_TRK_MODE_OFF;
			ratio_ff <= `POLSS_TRK_RATIO_DEF;
			mpct_ff <= `POLSS_MRG_DEF_PCT;
			share_ff <= 1'b0;
			spread_ff <= 1'b0;
			group_comm_bus_id_ff <= 5'h00;
		end else begin
			case (state_ff)
				`POLSS_ST_STRAP: begin
					vtgt_ff <= strap_vout;
					oclim_ff <= DEF_OC_LIMIT[VW-1:0];
					group_comm_bus_id_ff <= strap_addr;
				end
				`POLSS_ST_FACT: begin
					vtgt_ff <= fact_vout;
					oclim_ff <= fact_oc_limit;
				end
				`POLSS_ST_USER: begin
					if (user_valid) begin
						vtgt_ff <= user_vout;
						ocrsp_ff <= user_oc_resp;
					end
				end
				default: begin
					// host settings
					// judged on the same ready flag that the host sees
					if (ready_ff && cmd_wr) begin
						vtgt_ff <= cmd_vout;
						oclim_ff <= cmd_oc_limit;
						ocrsp_ff <= cmd_oc_resp;
						rmax_ff <= cmd_retry_max;
						rdly_ff <= cmd_retry_dly;
						dly_ff <= cmd_dly;
						ramp_ff <= cmd_ramp;
						trk_ff <= cmd_trk_mode;
						ratio_ff <= cmd_trk_ratio;
						mpct_ff <= cmd_mrg_pct;
						group_comm_bus_id_ff <= cmd_group_id;
						share_ff <= cmd_share;
						spread_ff <= cmd_spread;
					end
				end
			endcase
		end
	end

	// ****************************************
	// fault detection
	// ****************************************
	wire running = (state_ff == `POLSS_ST_RAMP) || (state_ff == `POLSS_ST_ON);
	wire peer_fault = spread_ff && gf_s2_ff && (id_s2_ff == group_comm_bus_id_ff);
	// fault time runs only while the over-current persists
	always @(posedge mclk) begin
		if (sys_rst) begin
			oc_tmr_ff <= {TW{1'b0}};
		end else if (running && oc_now) begin
			if (oc_tmr_ff != {TW{1'b1}}) begin
				oc_tmr_ff <= oc_tmr_ff + {{(TW-1){1'b0}}, 1'b1};
			end
		end else begin
			oc_tmr_ff <= {TW{1'b0}};
		end
	end
	wire own_trip = running && oc_now && (ocrsp_ff == `POLSS_RSP_RETRY_INF ||
		ocrsp_ff == `POLSS_RSP_RETRY_N || ocrsp_ff == `POLSS_RSP_SHUT_NOW ||
		(ocrsp_ff == `POLSS_RSP_DELAY_OFF && oc_tmr_ff >= rdly_ff));
	wire oc_trip = own_trip || (running && peer_fault);

	// ****************************************
	// sequencing and fault response
	// ****************************************
	reg [2:0] nxt_state;
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_ff <= `POLSS_ST_STRAP;
			tmr_ff <= {TW{1'b0}};
			retry_ff <= {NW{1'b0}};
			latched_ff <= 1'b0;
			acc_ff <= {(VW+9){1'b0}};
			vref_ff <= {VW{1'b0}};
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= (nxt_state != state_ff) ? {TW{1'b0}} : tmr_ff + {{(TW-1){1'b0}}, 1'b1};
			if (nxt_state == `POLSS_ST_OFF || nxt_state == `POLSS_ST_DELAY) begin
				acc_ff <= {(VW+9){1'b0}};
				vref_ff <= {VW{1'b0}};
			end else if (nxt_state == `POLSS_ST_RAMP) begin
				if (trk_ff != `POLSS_TRK_MODE_OFF) begin
					vref_ff <= trk_lim;
				end else begin
					acc_ff <= acc_ff + ramp_step;
					vref_ff <= (acc_ff[VW+8:8] > {1'b0, vtgt_ff}) ? vtgt_ff : acc_ff[VW+7:8];
				end
			end else if (nxt_state == `POLSS_ST_ON) begin
				vref_ff <= vmrg_sat;
			end
			if (nxt_state == `POLSS_ST_ON && !oc_now) begin
				retry_ff <= {NW{1'b0}};
			end
			if (!en_s2_ff) begin
				latched_ff <= 1'b0;
				retry_ff <= {NW{1'b0}};
			end else if (own_trip && ocrsp_ff == `POLSS_RSP_RETRY_N) begin
				if (retry_ff == rmax_ff) begin
					latched_ff <= 1'b1;
				end else begin
					retry_ff <= retry_ff + {{(NW-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			`POLSS_ST_STRAP: nxt_state = `POLSS_ST_FACT;
			`POLSS_ST_FACT: nxt_state = `POLSS_ST_USER;
			`POLSS_ST_USER: nxt_state = `POLSS_ST_BOOT;
			`POLSS_ST_BOOT: begin
				if (tmr_ff >= BOOT_CYC[TW-1:0]) nxt_state = `POLSS_ST_OFF;
			end
			`POLSS_ST_OFF: begin
				// common enable source
				// a latched retry count holds off until enable drops
				if (en_s2_ff && !latched_ff && !oc_now && !peer_fault &&
					(tmr_ff >= rdly_ff || ocrsp_ff == `POLSS_RSP_SHUT_NOW))
					nxt_state = `POLSS_ST_DELAY;
			end
			`POLSS_ST_DELAY: begin
				if (!en_s2_ff) nxt_state = `POLSS_ST_OFF;
				// leaving at eff_dly-1 keeps the state exactly eff_dly cycles
				else if (tmr_ff >= eff_dly - {{(TW-1){1'b0}}, 1'b1}) nxt_state = `POLSS_ST_RAMP;
			end
			`POLSS_ST_RAMP: begin
				if (!en_s2_ff || oc_trip) nxt_state = `POLSS_ST_OFF;
				else if (vref_ff == vtgt_ff) nxt_state = `POLSS_ST_ON;
			end
			`POLSS_ST_ON: begin
				if (!en_s2_ff || oc_trip) nxt_state = `POLSS_ST_OFF;
			end
			default: nxt_state = `POLSS_ST_STRAP;
		endcase
	end

	// ****************************************
	// status outputs
	// ****************************************
	always @(posedge mclk) begin
		if (sys_rst) begin
			pwm_en_ff <= 1'b0;
			diode_emul_ff <= 1'b1;
			overcurrent_protection_ff <= 1'b0;
			group_comm_bus_fault_out_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= booted;
			overcurrent_protection_ff <= oc_now;
			diode_emul_ff <= (nxt_state != `POLSS_ST_ON) && !(share_ff && trk_ff != `POLSS_TRK_MODE_OFF);
			pwm_en_ff <= (nxt_state == `POLSS_ST_RAMP) || (nxt_state == `POLSS_ST_ON);
			// broadcast own shutdown
			// a received fault is not echoed back onto the shared line
			group_comm_bus_fault_out_ff <= spread_ff && own_trip;
		end
	end
endmodule // polss_sequencer

// [tb/polss_chk.sv]
`timescale 1ns/1ps
module polss_chk #(parameter MIN_DLY_CYC = 20) (
	input wire mclk,
	input wire sys_rst,
	input wire enable_pin,
	input wire cmd_wr,
	input wire [2:0] cmd_oc_resp,
	input wire [4:0] cmd_group_id,
	input wire pwm_en_ff,
	input wire overcurrent_protection_ff,
	input wire group_comm_bus_fault_out_ff,
	input wire [4:0] group_comm_bus_id_ff,
	input wire ready_ff,
	input wire [2:0] state_ff
);
	reg [2:0] rsp_ff;
	reg [4:0] gid_ff;
	reg [23:0] dcnt_ff;
	// *****************
	// mirrored settings
	// *****************
	always @(posedge mclk) begin
		if (sys_rst) begin
			rsp_ff <= 3'h4;
			gid_ff <= 5'h0;
		end else if (cmd_wr && ready_ff) begin
			rsp_ff <= cmd_oc_resp;
			gid_ff <= cmd_group_id;
		end
		// delay length, cleared on leaving
		dcnt_ff <= (state_ff == 3'h5 && !sys_rst) ? dcnt_ff + 24'h1 : 24'h0;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_strap; $fell(sys_rst) |-> state_ff == 3'h0 && !pwm_en_ff; endproperty
	a_strap: assert property (p_strap) else $error("no strap load");
	property p_fact; state_ff == 3'h0 |=> state_ff == 3'h1; endproperty
	a_fact: assert property (p_fact) else $error("factory load skipped");
	property p_user; state_ff == 3'h1 |=> state_ff == 3'h2; endproperty
	a_user: assert property (p_user) else $error("user load skipped");
	property p_ready; ready_ff |-> state_ff[2]; endproperty
	a_ready: assert property (p_ready) else $error("ready during boot");
	property p_dly; state_ff != 3'h5 && pwm_en_ff && dcnt_ff != 24'h0
		|-> dcnt_ff >= MIN_DLY_CYC; endproperty
	a_dly: assert property (p_dly) else $error("delay too short");
	property p_shut; overcurrent_protection_ff && rsp_ff == 3'h4
		|-> ##[0:1] !pwm_en_ff; endproperty
	a_shut: assert property (p_shut) else $error("no shutdown");
	property p_ride; overcurrent_protection_ff && rsp_ff == 3'h3 && state_ff == 3'h7
		&& enable_pin |=> pwm_en_ff; endproperty
	a_ride: assert property (p_ride) else $error("ride through lost");
	property p_gid; group_comm_bus_fault_out_ff |-> group_comm_bus_id_ff == gid_ff; endproperty
	a_gid: assert property (p_gid) else $error("wrong rail id");
	property p_pulse; group_comm_bus_fault_out_ff |=> !group_comm_bus_fault_out_ff; endproperty
	a_pulse: assert property (p_pulse) else $error("broadcast too long");
endmodule // polss_chk
bind polss_sequencer polss_chk #(.MIN_DLY_CYC(MIN_DLY_CYC)) polss_chk_inst (.*);

// [tb/polss_peer.sv]
`timescale 1ns/1ps
module polss_peer (
	input wire mclk,
	input wire go,
	input wire [4:0] id,
	output reg fault = 1'h0,
	output reg [4:0] id_out = 5'h15
);
	always @(posedge mclk) begin
		fault <= go;
		// released id lines must not hold the old value
		id_out <= go ? id : ~id_out;
	end
endmodule // polss_peer

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	localparam MIN = 20;
	localparam DDLY = 40;
	reg mclk = 0, sys_rst = 1, enable_pin = 0, cmd_wr = 0, peer_go = 0;
	reg user_valid = 0, cmd_share = 0, cmd_spread = 1;
	reg [4:0] strap_addr = 0, cmd_group_id = 0, peer_id = 0, seen_id = 0;
	reg [11:0] strap_vout = 0, fact_vout = 0, user_vout = 0, cmd_vout = 12'h400, iout = 0;
	reg [11:0] fact_oc_limit = 12'h800, cmd_oc_limit = 0, track_voltage_input = 0;
	reg [2:0] user_oc_resp = 3'h3, cmd_oc_resp = 0;
	reg [3:0] cmd_retry_max = 4'h2;
	reg [23:0] cmd_retry_dly = 24'h1e, cmd_dly = 0, cmd_ramp = 24'h14, d;
	reg [1:0] cmd_trk_mode = 0, mrg_sel = 0;
	reg [7:0] cmd_trk_ratio = 8'h32, cmd_mrg_pct = 8'h05;
	wire group_comm_bus_fault_in, pwm_en_ff, diode_emul_ff, ready_ff;
	wire overcurrent_protection_ff, group_comm_bus_fault_out_ff;
	wire [4:0] group_comm_bus_id_in, group_comm_bus_id_ff;
	wire [11:0] vref_ff;
	wire [2:0] state_ff;
	integer n_fail = 0, checks_done = 0, seed = 32'h41e68a37, i, j, k;
	polss_sequencer #(.MIN_DLY_CYC(MIN), .DEF_DLY_CYC(DDLY), .DEF_RAMP_CYC(40),
		.BOOT_CYC(30), .DEF_RETRY_CYC(40)) polss_sequencer_inst (.*);
	polss_peer polss_peer_inst (.mclk(mclk), .go(peer_go), .id(peer_id),
		.fault(group_comm_bus_fault_in), .id_out(group_comm_bus_id_in));
	initial begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (group_comm_bus_fault_out_ff) seen_id <= group_comm_bus_id_ff;
	// *************
	// bench helpers
	// *************
	function [23:0] exp_dly(input [23:0] c);
		exp_dly = (c < MIN) ? MIN : c;
	endfunction
	task chk(input [23:0] e, input [23:0] g, input [63:0] nm);
		checks_done = checks_done + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("ERROR %0s exp %0h got %0h", nm, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wst(input [2:0] st);
		for (k = 0; state_ff !== st; k = k + 1) begin
			if (k == 3000) begin
				n_fail = n_fail + 1;
				test_done;
			end
			@(negedge mclk);
		end
	endtask
	task cmd(input [2:0] r, input [23:0] dl);
		@(posedge mclk);
		cmd_wr <= 1'h1;
		cmd_oc_resp <= r;
		cmd_dly <= dl;
		cmd_group_id <= 5'($random(seed));
		cmd_oc_limit <= 12'h100 + 12'({$random(seed)} % 1024);
		mrg_sel <= 2'({$random(seed)} % 3);
		cmd_ramp <= 24'h8 + 24'({$random(seed)} % 32);
		@(posedge mclk);
		cmd_wr <= 1'h0;
	endtask
	task run_up(input [23:0] e);
		@(posedge mclk);
		enable_pin <= 1'h1;
		wst(3'h5);
		for (j = 0; state_ff === 3'h5 && j < 3000; j = j + 1)
			@(negedge mclk);
		chk(e, j[23:0], "delay");
		wst(3'h7);
	endtask
	task trip(input integer n, input e);
		@(posedge mclk);
		iout <= 12'hfff;
		repeat (n) @(negedge mclk);
		chk(e, pwm_en_ff, "pwm");
	endtask
	task off;
		@(posedge mclk);
		enable_pin <= 1'h0;
		iout <= 12'h0;
		wst(3'h4);
	endtask
	initial begin
		strap_addr = 5'($random(seed));
		strap_vout = 12'($random(seed));
		fact_vout = 12'($random(seed));
		repeat (3) @(posedge mclk);
		sys_rst <= 1'h0;
		cmd(3'h3, 24'h5);
		wst(3'h4);
		@(negedge mclk);
		chk(1'h1, ready_ff, "ready");
		run_up(DDLY);
		trip(6, 1'h0);
		@(posedge mclk);
		iout <= 12'h0;
		wst(3'h7);
		$display("default start done");
		for (i = 0; i < 5; i = i + 1) begin
			off;
			d = i[0] ? 24'h5 : (i == 4 ? MIN : 24'h15 + 24'({$random(seed)} % 40));
			cmd(i[2:0], d);
			run_up(exp_dly(d));
			trip(6, i == 2 || i == 3);
			if (i > 1) trip(40, i == 3);
			$display("response %0d done", i);
		end
		chk(cmd_group_id, seen_id, "gid");
		off;
		run_up(MIN);
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge mclk);
			peer_id <= cmd_group_id ^ {4'h0, ~i[0]};
			peer_go <= 1'h1;
			@(posedge mclk);
			peer_go <= 1'h0;
			repeat (6) @(negedge mclk);
			chk(i, !pwm_en_ff, "peer");
		end
		$display("peer fault done");
		test_done;
	end
endmodule // testbench
